// ===== rtl/flash_reg_write.sv
// Serial command logic for register writes and the burst wrap length
module flash_reg_write
   import flash_reg_pkg::*;
#(
   parameter int unsigned NV_WRITE_CYC = NV_WRITE_CYCLES,
   parameter bit          TWO_DIE      = 1'b0,
   parameter bit          DIE_UPPER    = 1'b0
) (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic        CE,
   input  wire logic        SOFT_RESET,
   input  wire logic        SCK,
   input  wire logic        CS_N,
   input  wire logic        SI,
   input  wire logic        ERASE_FAIL,
   input  wire logic        PROGRAM_FAIL,
   input  wire logic        READ_LOAD,
   input  wire logic        READ_NEXT,
   input  wire logic        READ_QUAD,
   input  wire logic [31:0] READ_START,
   output logic      [7:0]  STATUS_ONE,
   output logic      [7:0]  CONFIG_TWO,
   output logic      [7:0]  CONFIG_FOUR,
   output logic      [7:0]  NV_CONFIG_FOUR,
   output logic      [31:0] READ_ADDR
);

   localparam logic [31:0] ERASE_LOAD = 32'(NV_WRITE_CYC / 2 - 1);
   localparam logic [31:0] PROG_LOAD  = 32'(NV_WRITE_CYC - NV_WRITE_CYC / 2 - 1);
   localparam logic [31:0] VOL_LOAD   = 32'(VOL_WRITE_CYCLES - 1);

   // Pin synchronisers; stage one feeds stage two only
   logic [2:0] sck_s;
   logic [2:0] cs_s;
   logic [1:0] si_s;
   logic       sck_rise;
   logic       cs_rise;

   frame_t      fr_q,    fr_d;
   logic [2:0]  bits_q,  bits_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  opc_q,   opc_d;
   logic [31:0] addr_q,  addr_d;
   logic [7:0]  data_q,  data_d;
   logic [1:0]  left_q,  left_d;
   logic [7:0]  byte_in;

   op_t         op_q,    op_d;
   logic [31:0] tmr_q,   tmr_d;
   logic [2:0]  pidx_q,  pidx_d;
   logic [7:0]  pval_q,  pval_d;
   logic        pwr_q,   pwr_d;
   logic [7:0]  v_q  [0:REG_COUNT-1];
   logic [7:0]  v_d  [0:REG_COUNT-1];
   logic [7:0]  nv_q [0:REG_COUNT-1];
   logic [7:0]  nv_d [0:REG_COUNT-1];

   logic        exec;
   logic        clr;
   logic        e_set;
   logic        p_set;
   logic        die_ok;
   logic [2:0]  idx;
   logic        to_nv;
   logic        to_vol;
   logic [7:0]  old_val;
   logic [7:0]  new_val;

   assign sck_rise = sck_s[1] & ~sck_s[2];
   assign cs_rise  = cs_s[1] & ~cs_s[2];
   assign byte_in  = {shift_q[6:0], si_s[1]};
   // Partial bytes never execute
   assign exec     = cs_rise && fr_q == FR_DONE && bits_q == 3'h0;

   function automatic logic [7:0] merge_bits(input logic [7:0] old, input logic [7:0] wr,
                                             input logic [7:0] ro,  input logic [7:0] otp,
                                             input logic [7:0] def);
      logic [7:0] moved;
      moved = old ^ def;
      merge_bits = (wr & ~ro & ~otp) | (old & ro)
                 | (otp & ((old & moved) | (wr & ~moved)));
   endfunction : merge_bits

   always_ff @(posedge CLK) begin
      if (RESET) begin
         sck_s <= 3'h0;
         cs_s  <= 3'h7;
         si_s  <= 2'h0;
      end else if (CE) begin
         sck_s <= {sck_s[1:0], SCK};
         cs_s  <= {cs_s[1:0], CS_N};
         si_s  <= {si_s[0], SI};
      end
   end

   // Serial frame: opcode, address, data, then ignore
   always_comb begin
      fr_d    = fr_q;
      bits_d  = bits_q;
      shift_d = shift_q;
      opc_d   = opc_q;
      addr_d  = addr_q;
      data_d  = data_q;
      left_d  = left_q;
      if (cs_s[1]) begin
         fr_d   = FR_OPC;
         bits_d = 3'h0;
      end else if (sck_rise) begin
         shift_d = byte_in;
         bits_d  = bits_q + 3'h1;
         if (bits_q == 3'h7) begin
            case (fr_q)
               FR_OPC: begin
                  opc_d  = byte_in;
                  addr_d = '0;
                  if (byte_in == OPC_WRITE_ANY) begin
                     fr_d   = FR_ADDR;
                     left_d = v_q[IDX_CFG2][BIT_ADDR_WIDE] ? ADDR_LEFT_WIDE
                                                           : ADDR_LEFT_NARROW;
                  end else if (byte_in == OPC_SET_WRAP) begin
                     fr_d = FR_DATA;
                  end else begin
                     fr_d = FR_DONE;
                  end
               end
               FR_ADDR: begin
                  addr_d = {addr_q[23:0], byte_in};
                  left_d = left_q - 2'h1;
                  if (left_q == 2'h0) begin
                     fr_d = FR_DATA;
                  end
               end
               FR_DATA: begin
                  data_d = byte_in;
                  fr_d   = FR_DONE;
               end
               default: begin
                  fr_d = FR_DONE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         fr_q    <= FR_OPC;
         bits_q  <= 3'h0;
         shift_q <= 8'h00;
         opc_q   <= 8'h00;
         addr_q  <= 32'h0000_0000;
         data_q  <= 8'h00;
         left_q  <= 2'h0;
      end else if (CE) begin
         fr_q    <= fr_d;
         bits_q  <= bits_d;
         shift_q <= shift_d;
         opc_q   <= opc_d;
         addr_q  <= addr_d;
         data_q  <= data_d;
         left_q  <= left_d;
      end
   end

   // Register banks and the update engine
   always_comb begin
      v_d    = v_q;
      nv_d   = nv_q;
      op_d   = op_q;
      tmr_d  = tmr_q;
      pidx_d = pidx_q;
      pval_d = pval_q;
      pwr_d  = pwr_q;
      e_set  = 1'b0;
      p_set  = 1'b0;
      clr    = exec && (opc_q == OPC_CLEAR_STATUS || opc_q == OPC_CLEAR_ALT);
      idx    = addr_q[2:0];
      die_ok = !TWO_DIE || (v_q[IDX_CFG2][BIT_ADDR_WIDE]
                            && addr_q[DIE_ADDR_BIT] == DIE_UPPER);
      to_nv  = idx < 3'(REG_COUNT) && (addr_q[23:0] & ~REG_IDX_MASK) == REG_NV_BASE;
      to_vol = idx < 3'(REG_COUNT) && (addr_q[23:0] & ~REG_IDX_MASK) == REG_VOL_BASE;
      old_val = to_nv ? nv_q[idx] : v_q[idx];
      new_val = merge_bits(old_val, data_q, RO_MASK[idx], OTP_MASK[idx],
                           NV_DEFAULT[idx]);
      case (op_q)
         OP_VOL: begin
            if (tmr_q == 32'h0) begin
               if (pwr_q) begin
                  v_d[pidx_q] = pval_q;
               end
               v_d[IDX_STATUS][BIT_WR_LATCH] = 1'b0;
               op_d = OP_IDLE;
            end else begin
               tmr_d = tmr_q - 32'h1;
            end
         end
         OP_ERASE: begin
            if (tmr_q == 32'h0) begin
               if (ERASE_FAIL) begin
                  e_set = 1'b1;
                  op_d  = OP_FAIL;
               end else begin
                  op_d  = OP_PROG;
                  tmr_d = PROG_LOAD;
               end
            end else begin
               tmr_d = tmr_q - 32'h1;
            end
         end
         OP_PROG: begin
            if (tmr_q == 32'h0) begin
               if (PROGRAM_FAIL) begin
                  p_set = 1'b1;
                  op_d  = OP_FAIL;
               end else begin
                  nv_d[pidx_q] = pval_q;
                  v_d[IDX_STATUS][BIT_WR_LATCH] = 1'b0;
                  op_d = OP_IDLE;
               end
            end else begin
               tmr_d = tmr_q - 32'h1;
            end
         end
         OP_FAIL: begin
            if (clr) begin
               v_d[IDX_STATUS][BIT_WR_LATCH] = 1'b0;
               op_d = OP_IDLE;
            end
         end
         default: begin
            // Only the status clear is taken while busy
            if (exec) begin
               if (opc_q == OPC_WRITE_ENABLE) begin
                  v_d[IDX_STATUS][BIT_WR_LATCH] = 1'b1;
               end else if (opc_q == OPC_WRITE_DISABLE) begin
                  v_d[IDX_STATUS][BIT_WR_LATCH] = 1'b0;
               end else if (opc_q == OPC_WIDE_ADDRESS) begin
                  v_d[IDX_CFG2][BIT_ADDR_WIDE] = 1'b1;
               end else if (opc_q == OPC_SET_WRAP) begin
                  v_d[IDX_CFG4] = (v_q[IDX_CFG4] & ~WRAP_FIELD_MASK)
                                | (data_q & WRAP_FIELD_MASK);
               end else if (opc_q == OPC_WRITE_ANY && v_q[IDX_STATUS][BIT_WR_LATCH]
                            && die_ok) begin
                  // Lock latch address matches neither bank, so nothing is stored
                  pidx_d = idx;
                  pval_d = new_val;
                  pwr_d  = to_vol && new_val != old_val;
                  op_d   = OP_VOL;
                  tmr_d  = VOL_LOAD;
                  if (to_nv && new_val != old_val) begin
                     pwr_d = 1'b0;
                     op_d  = OP_ERASE;
                     tmr_d = ERASE_LOAD;
                  end
               end
            end
         end
      endcase
      // Flags set by hardware win over a clear in the same cycle
      v_d[IDX_STATUS][BIT_ERASE_ERR] = (v_q[IDX_STATUS][BIT_ERASE_ERR] & ~clr) | e_set;
      v_d[IDX_STATUS][BIT_PROG_ERR]  = (v_q[IDX_STATUS][BIT_PROG_ERR] & ~clr) | p_set;
      if (SOFT_RESET) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            v_d[i] = nv_q[i] & ~RO_MASK[i];
         end
         op_d = OP_IDLE;
      end
      v_d[IDX_STATUS][BIT_BUSY] = op_d != OP_IDLE;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         op_q   <= OP_IDLE;
         tmr_q  <= 32'h0;
         pidx_q <= 3'h0;
         pval_q <= 8'h00;
         pwr_q  <= 1'b0;
         for (int i = 0; i < REG_COUNT; i++) begin
            nv_q[i] <= NV_DEFAULT[i];
            v_q[i]  <= NV_DEFAULT[i] & ~RO_MASK[i];
         end
      end else if (CE) begin
         op_q   <= op_d;
         tmr_q  <= tmr_d;
         pidx_q <= pidx_d;
         pval_q <= pval_d;
         pwr_q  <= pwr_d;
         v_q    <= v_d;
         nv_q   <= nv_d;
      end
   end

   assign STATUS_ONE     = v_q[IDX_STATUS];
   assign CONFIG_TWO     = v_q[IDX_CFG2];
   assign CONFIG_FOUR    = v_q[IDX_CFG4];
   assign NV_CONFIG_FOUR = nv_q[IDX_CFG4];

   // Wrap settings are sampled when a read loads its start address
   wrap_addr_seq #(
      .AW (32)
   ) u_seq (
      .clk        (CLK),
      .rst        (RESET),
      .ce         (CE),
      .load       (READ_LOAD),
      .next       (READ_NEXT),
      .wrap_en    (READ_QUAD && !v_q[IDX_CFG4][BIT_WRAP_OFF]),
      .wrap_len   (v_q[IDX_CFG4][1:0]),
      .start_addr (READ_START),
      .addr_q     (READ_ADDR)
   );

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET || !CE || SOFT_RESET);

   property p_enable_sets;
      exec && op_q == OP_IDLE && opc_q == OPC_WRITE_ENABLE |=> STATUS_ONE[BIT_WR_LATCH];
   endproperty
   a_enable_sets: assert property (p_enable_sets) else $error("enable latch not set");

   property p_write_refused;
      exec && op_q == OP_IDLE && opc_q == OPC_WRITE_ANY && !STATUS_ONE[BIT_WR_LATCH]
         |=> op_q == OP_IDLE && !STATUS_ONE[BIT_BUSY];
   endproperty
   a_write_refused: assert property (p_write_refused) else $error("write without enable");

   property p_busy_on_start;
      op_q == OP_IDLE && op_d != OP_IDLE |=> STATUS_ONE[BIT_BUSY] throughout (op_q != OP_IDLE);
   endproperty
   a_busy_on_start: assert property (p_busy_on_start) else $error("busy missing");

   property p_fail_holds;
      op_q == OP_FAIL && !clr |=> STATUS_ONE[BIT_BUSY]
         && (STATUS_ONE[BIT_PROG_ERR] || STATUS_ONE[BIT_ERASE_ERR]);
   endproperty
   a_fail_holds: assert property (p_fail_holds) else $error("failure not held");

   property p_clear_ends;
      clr && op_q == OP_FAIL |=> !STATUS_ONE[BIT_BUSY] && !STATUS_ONE[BIT_PROG_ERR]
         && !STATUS_ONE[BIT_ERASE_ERR];
   endproperty
   a_clear_ends: assert property (p_clear_ends) else $error("clear left status");

   property p_vol_time;
      op_q == OP_IDLE && op_d == OP_VOL |=> ##[1:5] op_q == OP_IDLE;
   endproperty
   a_vol_time: assert property (p_vol_time) else $error("volatile update late");

   property p_wrap_fields;
      exec && op_q == OP_IDLE && opc_q == OPC_SET_WRAP |=>
         ((CONFIG_FOUR ^ $past(CONFIG_FOUR)) & ~WRAP_FIELD_MASK) == 8'h00
         && (CONFIG_FOUR & WRAP_FIELD_MASK) == ($past(data_q) & WRAP_FIELD_MASK);
   endproperty
   a_wrap_fields: assert property (p_wrap_fields) else $error("wrap fields wrong");

   property p_lock_untouched;
      exec && op_q == OP_IDLE && opc_q == OPC_WRITE_ANY && addr_q[23:0] == REG_LOCK_ADDR
         |=> !pwr_q && op_q != OP_ERASE;
   endproperty
   a_lock_untouched: assert property (p_lock_untouched) else $error("lock reg written");

   property p_partial_dropped;
      cs_rise && bits_q != 3'h0 && op_q == OP_IDLE |=> op_q == OP_IDLE
         && CONFIG_FOUR == $past(CONFIG_FOUR) && STATUS_ONE == $past(STATUS_ONE);
   endproperty
   a_partial_dropped: assert property (p_partial_dropped) else $error("partial frame ran");

   c_nv_done: cover property (op_q == OP_PROG && op_d == OP_IDLE);
   c_fail:    cover property (op_q == OP_FAIL && clr);
   c_wrap:    cover property (exec && opc_q == OPC_SET_WRAP);

endmodule : flash_reg_write

// ===== common/flash_reg_pkg.sv
// Constants and types for the register-write and wrap-length command logic
package flash_reg_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS     = 10;
   localparam int unsigned VOL_WRITE_TIME_NS = 50;
   localparam int unsigned NV_WRITE_TIME_US  = 500;
   localparam int unsigned VOL_WRITE_CYCLES  =
      (VOL_WRITE_TIME_NS / CLK_PERIOD_NS) > 0 ? VOL_WRITE_TIME_NS / CLK_PERIOD_NS : 1;
   localparam int unsigned NV_WRITE_CYCLES   = (NV_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;

   // Instruction codes
   localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OPC_CLEAR_STATUS  = 8'h30;
   localparam logic [7:0] OPC_CLEAR_ALT     = 8'h82;
   localparam logic [7:0] OPC_WIDE_ADDRESS  = 8'hb7;
   localparam logic [7:0] OPC_WRITE_ANY     = 8'h71;
   localparam logic [7:0] OPC_SET_WRAP      = 8'hc0;

   // Register indices inside each bank
   localparam int unsigned REG_COUNT  = 6;
   localparam logic [2:0]  IDX_STATUS = 3'h0;
   localparam logic [2:0]  IDX_CFG2   = 3'h3;
   localparam logic [2:0]  IDX_CFG4   = 3'h5;

   // Register address decode
   localparam logic [23:0] REG_IDX_MASK  = 24'h000007;
   localparam logic [23:0] REG_NV_BASE   = 24'h000000;
   localparam logic [23:0] REG_VOL_BASE  = 24'h800000;
   localparam logic [23:0] REG_LOCK_ADDR = 24'h800040;
   localparam int unsigned DIE_ADDR_BIT  = 26;

   // Bit positions
   localparam int unsigned BIT_BUSY      = 0;
   localparam int unsigned BIT_WR_LATCH  = 1;
   localparam int unsigned BIT_ERASE_ERR = 5;
   localparam int unsigned BIT_PROG_ERR  = 6;
   localparam int unsigned BIT_ADDR_WIDE = 7;
   localparam int unsigned BIT_WRAP_OFF  = 4;
   localparam logic [7:0]  WRAP_FIELD_MASK = 8'h13;
   localparam logic [1:0]  ADDR_LEFT_NARROW = 2'h2;
   localparam logic [1:0]  ADDR_LEFT_WIDE   = 2'h3;

   // Per-register bit types and values after power-on
   localparam logic [7:0] NV_DEFAULT [0:REG_COUNT-1] =
      '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h10};
   localparam logic [7:0] RO_MASK    [0:REG_COUNT-1] =
      '{8'h63, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] OTP_MASK   [0:REG_COUNT-1] =
      '{8'h00, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h00};

   // Wrap group arithmetic
   localparam logic [6:0] WRAP_MIN_GROUP = 7'h08;

   typedef enum logic [1:0] {
      FR_OPC  = 2'b00,
      FR_ADDR = 2'b01,
      FR_DATA = 2'b10,
      FR_DONE = 2'b11
   } frame_t;

   typedef enum logic [2:0] {
      OP_IDLE  = 3'b000,
      OP_VOL   = 3'b001,
      OP_ERASE = 3'b010,
      OP_PROG  = 3'b011,
      OP_FAIL  = 3'b100
   } op_t;

endpackage : flash_reg_pkg

// ===== rtl/wrap_addr_seq.sv
// Read byte-address sequencer with optional aligned wrap groups
module wrap_addr_seq
   import flash_reg_pkg::*;
#(
   parameter int unsigned AW = 32
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic          load,
   input  wire logic          next,
   input  wire logic          wrap_en,
   input  wire logic [1:0]    wrap_len,
   input  wire logic [AW-1:0] start_addr,
   output logic      [AW-1:0] addr_q
);

   logic [AW-1:0] addr_d;
   logic [AW-1:0] inc;
   logic [5:0]    mask_q;
   logic [5:0]    mask_d;
   logic          wrap_q;
   logic          wrap_d;

   always_comb begin
      addr_d = addr_q;
      mask_d = mask_q;
      wrap_d = wrap_q;
      inc    = addr_q + AW'(1);
      if (load) begin
         addr_d = start_addr;
         wrap_d = wrap_en;
         mask_d = 6'((WRAP_MIN_GROUP << wrap_len) - 7'h01);
      end else if (next) begin
         if (wrap_q) begin
            addr_d = {addr_q[AW-1:6], (addr_q[5:0] & ~mask_q) | (inc[5:0] & mask_q)};
         end else begin
            addr_d = inc;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_q <= '0;
         mask_q <= '0;
         wrap_q <= 1'b0;
      end else if (ce) begin
         addr_q <= addr_d;
         mask_q <= mask_d;
         wrap_q <= wrap_d;
      end
   end

   property p_wrap_in_group;
      @(posedge clk) disable iff (rst)
      ce && !load && next && wrap_q |=>
         (addr_q & ~AW'(mask_q)) == $past(addr_q & ~AW'(mask_q));
   endproperty
   a_wrap_in_group: assert property (p_wrap_in_group) else $error("wrap left its group");

   property p_seq_step;
      @(posedge clk) disable iff (rst)
      ce && !load && next && !wrap_q |=> addr_q == $past(addr_q) + AW'(1);
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("sequential read did not step");

   c_wrap_turn: cover property (@(posedge clk) disable iff (rst)
      ce && next && wrap_q && ((addr_q[5:0] & mask_q) == mask_q));

endmodule : wrap_addr_seq

// ===== tb/spi_host_model.sv
// SPI host model: mode 0 frames on chip select, clock and data in
module spi_host_model (
   output logic SCK,
   output logic CS_N,
   output logic SI
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam real HALF = 62.5;
   initial begin
      SCK  = 1'b0;
      CS_N = 1'b1;
      SI   = 1'b1;
   end
   // Cut drops trailing bits so a frame can end mid-byte
   task automatic xfer(input logic [7:0] q[$], input int cut);
      int n;
      n = q.size() * 8 - cut;
      CS_N = 1'b0;
      for (int i = 0; i < n; i++) begin
         SI = q[i / 8][7 - i % 8];
         #(HALF);
         SCK = 1'b1;
         #(HALF);
         SCK = 1'b0;
      end
      #(HALF);
      CS_N = 1'b1;
      // Released line shows the inverse, never a stale bit
      SI = ~SI;
      #(2 * HALF);
   endtask : xfer
endmodule : spi_host_model

// ===== tb/flash_reg_write_bench.sv
// Self-checking bench for the register-write and wrap-length logic
module flash_reg_write_bench;
   import flash_reg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned NV_CYC = 20;
   localparam logic [31:0] BASE   = 32'h12345640;
   logic        clk, reset, soft_reset, erase_fail, program_fail, ce;
   logic        read_load, read_next, read_quad;
   logic [31:0] read_start, read_addr;
   logic [7:0]  status_one, config_two, config_four, nv_config_four;
   wire logic   sck, cs_n, si;
   int          mismatches, n_checks;

   spi_host_model u_host (.SCK(sck), .CS_N(cs_n), .SI(si));
   flash_reg_write #(.NV_WRITE_CYC(NV_CYC)) u_dut (
      .CLK(clk), .RESET(reset), .CE(ce), .SOFT_RESET(soft_reset),
      .SCK(sck), .CS_N(cs_n), .SI(si), .ERASE_FAIL(erase_fail),
      .PROGRAM_FAIL(program_fail), .READ_LOAD(read_load), .READ_NEXT(read_next),
      .READ_QUAD(read_quad), .READ_START(read_start), .STATUS_ONE(status_one),
      .CONFIG_TWO(config_two), .CONFIG_FOUR(config_four),
      .NV_CONFIG_FOUR(nv_config_four), .READ_ADDR(read_addr));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // Bounded poll of the busy bit
   task automatic wait_idle();
      for (int i = 0; i < 200 && status_one[0] !== 1'b0; i++) @(negedge clk);
      chk(status_one[0], 1'b0);
   endtask : wait_idle

   task automatic arm_write();
      u_host.xfer('{OPC_WRITE_ENABLE}, 0);
      cyc(4);
   endtask : arm_write

   task automatic walk(input logic [31:0] start, input logic quad, input logic [31:0] e1);
      @(negedge clk);
      read_start = start;
      read_quad  = quad;
      read_load  = 1'b1;
      @(negedge clk);
      read_load = 1'b0;
      chk(read_addr, start);
      read_next = 1'b1;
      @(negedge clk);
      read_next = 1'b0;
      chk(read_addr, e1);
   endtask : walk

   task automatic t_reset_and_refuse();
      chk({status_one, config_two, config_four, nv_config_four}, 32'h00081010);
      u_host.xfer('{OPC_WRITE_ANY, 8'h80, 8'h00, 8'h05, 8'he4}, 0);
      cyc(10);
      chk(status_one, 8'h00);
      chk(config_four, 8'h10);
      arm_write();
      u_host.xfer('{OPC_WRITE_DISABLE}, 0);
      cyc(4);
      chk(status_one, 8'h00);
      $display("test reset_and_refuse finished");
   endtask : t_reset_and_refuse

   task automatic t_volatile();
      arm_write();
      chk(status_one, 8'h02);
      u_host.xfer('{OPC_WRITE_ANY, 8'h80, 8'h00, 8'h05, 8'he4}, 4);
      cyc(10);
      chk(config_four, 8'h10);
      arm_write();
      u_host.xfer('{OPC_WRITE_ANY, 8'h80, 8'h00, 8'h05, 8'he4}, 0);
      wait_idle();
      chk(config_four, 8'he4);
      chk(status_one, 8'h00);
      arm_write();
      u_host.xfer('{OPC_WRITE_ANY, 8'h80, 8'h00, 8'h00, 8'h60}, 0);
      wait_idle();
      chk(status_one, 8'h00);
      // Lock latch address must leave every register alone
      arm_write();
      u_host.xfer('{OPC_WRITE_ANY, 8'h80, 8'h00, 8'h40, 8'hff}, 0);
      wait_idle();
      chk(config_four, 8'he4);
      chk(status_one, 8'h00);
      $display("test volatile finished");
   endtask : t_volatile

   task automatic t_wrap();
      logic [31:0] grp;
      for (int len = 0; len < 4; len++) begin
         grp = 32'h8 << len;
         u_host.xfer('{OPC_SET_WRAP, 8'(len)}, 0);
         cyc(4);
         chk(config_four, 8'he4 | 8'(len));
         walk(BASE + grp - 1, 1'b1, BASE);
         walk(BASE + grp - 1, 1'b0, BASE + grp);
      end
      u_host.xfer('{OPC_SET_WRAP, 8'hff}, 0);
      cyc(4);
      chk(config_four, 8'hf7);
      walk(BASE + 7, 1'b1, BASE + 8);
      $display("test wrap finished");
   endtask : t_wrap

   task automatic t_nv_fail();
      for (int k = 0; k < 2; k++) begin
         erase_fail   = (k == 0);
         program_fail = (k == 1);
         arm_write();
         u_host.xfer('{OPC_WRITE_ANY, 8'h00, 8'h00, 8'h05, 8'h03}, 0);
         chk(status_one[0], 1'b1);
         cyc(NV_CYC + 30);
         chk(status_one & 8'h61, k ? 8'h41 : 8'h21);
         erase_fail   = 1'b0;
         program_fail = 1'b0;
         u_host.xfer('{k ? OPC_CLEAR_ALT : OPC_CLEAR_STATUS}, 0);
         cyc(2);
         chk(status_one & 8'h61, 8'h00);
      end
      $display("test nv_fail finished");
   endtask : t_nv_fail

   task automatic t_nv_ok();
      arm_write();
      u_host.xfer('{OPC_WRITE_ANY, 8'h00, 8'h00, 8'h05, 8'h03}, 0);
      chk(status_one[0], 1'b1);
      wait_idle();
      chk(nv_config_four, 8'h03);
      soft_reset = 1'b1;
      cyc(1);
      soft_reset = 1'b0;
      cyc(2);
      chk(config_four, 8'h03);
      // A frame sent while the clock enable is low must be lost whole
      ce = 1'b0;
      u_host.xfer('{OPC_WIDE_ADDRESS}, 0);
      cyc(4);
      ce = 1'b1;
      cyc(4);
      chk(config_two, 8'h08);
      u_host.xfer('{OPC_WIDE_ADDRESS}, 0);
      cyc(4);
      chk(config_two, 8'h88);
      arm_write();
      u_host.xfer('{OPC_WRITE_ANY, 8'h00, 8'h80, 8'h00, 8'h05, 8'he0}, 0);
      wait_idle();
      chk(config_four, 8'he0);
      $display("test nv_ok finished");
   endtask : t_nv_ok

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   // Whole run needs roughly 80 us
   initial begin
      #600us;
      mismatches++;
      conclude();
   end

   initial begin
      {reset, soft_reset, erase_fail, program_fail} = 4'h8;
      {read_load, read_next, read_quad} = 3'h0;
      ce = 1'b1;
      read_start = 32'h0;
      mismatches = 0;
      n_checks   = 0;
      cyc(2);
      reset = 1'b0;
      cyc(2);
      t_reset_and_refuse();
      t_volatile();
      t_wrap();
      t_nv_fail();
      t_nv_ok();
      conclude();
   end
endmodule : flash_reg_write_bench
